// ==== wcs_pkg.sv ====
// Summary of operation
// - Overflow with action bit set requests reset
// - Reset request resets chip, then warm-up
// - Clear code zeroes counter, counting continues
// - Disable code stops watchdog only when disabled
// - Clear beats coincident overflow, no event
// - Counter monitor reads count without disturbing
// - Active flag shows running state
// - Overflow interrupt sets overflow cause flag
// - Out-of-window clear sets window cause flag
// - Status read clears the cause flags it reports
// - Set wins over coincident status read
// - Action bit clear gives NMI, keeps counting
// - Out-of-window clear: interrupt, no clear
// - Run enable starts; disabling zeroes counter
// - Window select 00 accepts clear anytime
package wcs_pkg;
  localparam logic [11:0] WCS_CTRL_OFS = 12'h000;
  localparam logic [11:0] WCS_CODE_OFS = 12'h004;
  localparam logic [11:0] WCS_CNT_OFS = 12'h008;
  localparam logic [11:0] WCS_STAT_OFS = 12'h00C;
  localparam logic [7:0] WCS_CLEAR_CODE = 8'h4E;
  localparam logic [7:0] WCS_DISABLE_CODE = 8'hB1;
  // Control field positions
  localparam int WCS_CTRL_EN_BIT = 7;
  localparam int WCS_CTRL_WIN_LO = 5;
  localparam int WCS_CTRL_TT_LO = 2;
  localparam int WCS_CTRL_OUT_BIT = 0;
  localparam logic [7:0] WCS_CTRL_RST = 8'h80;
  localparam logic [4:0] WCS_STAT_HI_RST = 5'h0B;
  localparam logic [1:0] WCS_WIN_ANY = 2'h0;
  localparam int WCS_DIV_DEFAULT = 64;
  localparam int WCS_WARM_DEFAULT = 16;
endpackage

// ==== wcs_evt_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface wcs_evt_if;
  logic clr_wr;
  logic dis_wr;
  logic tick;
  logic run;
  logic [1:0] win_sel;
  logic [7:0] count;
  logic ovf_evt;
  logic win_evt;
  modport ctr (input clr_wr, input dis_wr, input tick, input run, input win_sel,
    output count, output ovf_evt, output win_evt);
  modport ctl (output clr_wr, output dis_wr, output tick, output run, output win_sel,
    input count, input ovf_evt, input win_evt);
endinterface
`default_nettype wire

// ==== wcs_divider.sv ====
`timescale 1ns/10ps
`default_nettype none
module wcs_divider
  import wcs_pkg::*;
#(
  parameter int DIV = WCS_DIV_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] rate_sel,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } wcs_div_s;
  wcs_div_s st_r;
  wcs_div_s st_nxt;
  logic [15:0] limit;
  // Refuse a divide ratio the 16-bit limit cannot hold
  if (DIV < 1 || DIV > 8191) begin : g_div_chk
    $error("DIV out of range");
  end
  // Limit scales by 1,2,4,8 with rate select
  always_comb begin
    limit = 16'(DIV) << rate_sel;
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= limit - 16'h0001) begin
      st_nxt.cnt = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign tick = st_r.tick;
endmodule
`default_nettype wire

// ==== wcs_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
module wcs_counter
  import wcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  wcs_evt_if.ctr evt
);
  typedef struct packed {
    logic [7:0] count;
    logic ovf;
    logic win;
  } wcs_cnt_s;
  wcs_cnt_s st_r;
  wcs_cnt_s st_nxt;
  logic in_win;
  // Window opens in the upper half, quarter or eighth of the period; select 00 keeps it open
  always_comb begin
    unique case (evt.win_sel)
      2'h0: in_win = 1'b1;
      2'h1: in_win = st_r.count[7];
      2'h2: in_win = st_r.count[7] & st_r.count[6];
      2'h3: in_win = &st_r.count[7:5];
    endcase
  end
  // Counter update with clear priority
  always_comb begin
    st_nxt = st_r;
    st_nxt.ovf = 1'b0;
    st_nxt.win = 1'b0;
    if (!evt.run || evt.dis_wr) begin
      st_nxt.count = 8'h00;
    end else if (evt.clr_wr && in_win) begin
      st_nxt.count = 8'h00;
    end else begin
      if (evt.clr_wr) begin
        st_nxt.win = 1'b1;
      end
      if (evt.tick) begin
        st_nxt.count = st_r.count + 8'h01;
        st_nxt.ovf = (st_r.count == 8'hFF);
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign evt.count = st_r.count;
  assign evt.ovf_evt = st_r.ovf;
  assign evt.win_evt = st_r.win;
endmodule
`default_nettype wire

// ==== wcs_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module wcs_top
  import wcs_pkg::*;
#(
  parameter int DIV = WCS_DIV_DEFAULT,
  parameter int WARM = WCS_WARM_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wdt_nmi_req,
  output logic wdt_reset_req
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic running;
    logic ovf_cause;
    logic win_cause;
    logic [31:0] rdata;
    logic err;
    logic nmi;
    logic rst_req;
    logic [7:0] warm;
    logic clr_wr;
    logic dis_wr;
  } wcs_top_s;
  wcs_top_s st_r;
  wcs_top_s st_nxt;
  wcs_evt_if evt();
  logic tick;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] stat;
  // Status bit positions of the two cause flags
  localparam int STAT_OVF_BIT = 2;
  localparam int STAT_WIN_BIT = 1;
  // Refuse a warm-up length the 8-bit counter cannot hold
  if (WARM < 1 || WARM > 255) begin : g_warm_chk
    $error("WARM out of range");
  end
  wcs_divider #(.DIV(DIV)) u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rate_sel(st_r.ctrl[WCS_CTRL_TT_LO +: 2]),
    .tick(tick)
  );
  wcs_counter u_cnt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .evt(evt.ctr)
  );
  // Signals toward the counter
  assign evt.clr_wr = st_r.clr_wr;
  assign evt.dis_wr = st_r.dis_wr;
  assign evt.tick = tick & st_r.running & (st_r.warm == 8'h00);
  assign evt.run = st_r.running;
  assign evt.win_sel = st_r.ctrl[WCS_CTRL_WIN_LO +: 2];
  // APB decode, zero wait states
  assign acc = psel & penable;
  assign wr = acc & pwrite & pstrb[0];
  assign rd = acc & ~pwrite;
  assign mapped = (paddr == WCS_CTRL_OFS) || (paddr == WCS_CODE_OFS) ||
    (paddr == WCS_CNT_OFS) || (paddr == WCS_STAT_OFS);
  assign stat = {WCS_STAT_HI_RST, st_r.ovf_cause, st_r.win_cause, st_r.running};
  // Register and event logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.clr_wr = 1'b0;
    st_nxt.dis_wr = 1'b0;
    st_nxt.nmi = 1'b0;
    st_nxt.err = 1'b0;
    if (st_r.warm != 8'h00) begin
      st_nxt.warm = st_r.warm - 8'h01;
    end
    if (wr && paddr == WCS_CTRL_OFS) begin
      st_nxt.ctrl = pwdata[7:0];
      if (pwdata[WCS_CTRL_EN_BIT]) begin
        st_nxt.running = 1'b1;
      end
    end
    if (wr && paddr == WCS_CODE_OFS) begin
      if (pwdata[7:0] == WCS_CLEAR_CODE) begin
        st_nxt.clr_wr = 1'b1;
      end else if (pwdata[7:0] == WCS_DISABLE_CODE && !st_r.ctrl[WCS_CTRL_EN_BIT]) begin
        st_nxt.running = 1'b0;
        st_nxt.dis_wr = 1'b1;
      end
    end
    if (acc && !mapped) begin
      st_nxt.err = 1'b1;
    end
    // Read data latched in setup, so it stands at the access edge
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        WCS_CTRL_OFS: st_nxt.rdata = {24'h000000, st_r.ctrl};
        WCS_CNT_OFS: st_nxt.rdata = {24'h000000, evt.count};
        WCS_STAT_OFS: st_nxt.rdata = {24'h000000, stat};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
    // Clear only causes this read reported, a later set is not lost
    if (rd && paddr == WCS_STAT_OFS) begin
      if (st_r.rdata[STAT_OVF_BIT]) begin
        st_nxt.ovf_cause = 1'b0;
      end
      if (st_r.rdata[STAT_WIN_BIT]) begin
        st_nxt.win_cause = 1'b0;
      end
    end
    // Events after the read so set wins
    if (evt.ovf_evt) begin
      if (st_r.ctrl[WCS_CTRL_OUT_BIT]) begin
        st_nxt.rst_req = 1'b1;
      end else begin
        st_nxt.nmi = 1'b1;
        st_nxt.ovf_cause = 1'b1;
      end
    end
    if (evt.win_evt) begin
      st_nxt.nmi = 1'b1;
      st_nxt.win_cause = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.ctrl <= WCS_CTRL_RST;
      st_r.running <= 1'b1;
      st_r.warm <= 8'(WARM);
    end else begin
      st_r <= st_nxt;
    end
  end
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign wdt_nmi_req = st_r.nmi;
  assign wdt_reset_req = st_r.rst_req;
endmodule
`default_nettype wire

// ==== wcs_top_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module wcs_top_properties
  import wcs_pkg::*;
#(
  parameter int DIV = WCS_DIV_DEFAULT,
  parameter int WARM = WCS_WARM_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wdt_nmi_req,
  input wire logic wdt_reset_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Access phase decode
  logic acc, bad, rd_st, rd_cn, rd_cd;
  assign acc = psel && penable;
  assign bad = acc && !(paddr inside {WCS_CTRL_OFS, WCS_CODE_OFS, WCS_CNT_OFS, WCS_STAT_OFS});
  assign rd_st = acc && !pwrite && paddr == WCS_STAT_OFS;
  assign rd_cn = acc && !pwrite && paddr == WCS_CNT_OFS;
  assign rd_cd = acc && !pwrite && paddr == WCS_CODE_OFS;
  // Two status reads with no interrupt from the first read until the cycle before the second
  sequence quiet_rd;
    rd_st && !wdt_nmi_req;
  endsequence
  sequence two_stat;
    quiet_rd ##1 (!wdt_nmi_req) [*2] ##1 rd_st;
  endsequence
  rdy_high_a: assert property (pready) else $error("pready low");
  serr_bad_a: assert property (bad |-> pslverr) else $error("no error on unmapped");
  serr_good_a: assert property (!bad |-> !pslverr) else $error("spurious pslverr");
  rst_stick_a: assert property (wdt_reset_req |=> wdt_reset_req)
    else $error("reset request dropped");
  nmi_pulse_a: assert property (wdt_nmi_req |=> !wdt_nmi_req)
    else $error("nmi longer than one cycle");
  code_zero_a: assert property (rd_cd |-> prdata == 32'h0)
    else $error("code port read not zero");
  stat_fix_a: assert property (rd_st |-> prdata[31:3] == {24'h0, WCS_STAT_HI_RST})
    else $error("status fixed bits wrong");
  cnt_wide_a: assert property (rd_cn |-> prdata[31:8] == 24'h0)
    else $error("counter upper bits set");
  stat_clr_a: assert property (two_stat |-> prdata[2:1] == 2'h0)
    else $error("cause flags not cleared by read");
endmodule
bind wcs_top wcs_top_properties #(.DIV(DIV), .WARM(WARM)) u_wcs_top_properties (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wdt_nmi_req(wdt_nmi_req), .wdt_reset_req(wdt_reset_req));
`default_nettype wire

// ==== wcs_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module wcs_top_test
  import wcs_pkg::*;
;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, wdt_nmi_req, wdt_reset_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, c;
  logic [3:0] pstrb;
  logic err_v;
  int failures, n_tests, n_nmi, i;
  wcs_top #(.DIV(1)) u_wcs_top (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_nmi_req(wdt_nmi_req),
    .wdt_reset_req(wdt_reset_req));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Interrupt pulse tally
  always @(posedge clk_sys) if (wdt_nmi_req === 1'b1) n_nmi++;
  // One APB transfer, read data kept in rd_v
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    // Answer taken at the ready edge, then released
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic st(input logic [31:0] e);
    xfer(1'b0, WCS_STAT_OFS, 32'h0);
    cmp("status", e, rd_v);
  endtask
  // Waits for one interrupt pulse
  task automatic nmi_wait();
    i = n_nmi;
    repeat (300) if (n_nmi == i) @(posedge clk_sys);
    cmp("nmi count", 32'h1, n_nmi - i);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog on the run
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    st(32'h59);
    xfer(1'b0, WCS_CODE_OFS, 32'h0);
    cmp("code read", 32'h0, rd_v);
    cmp("pslverr mapped", 32'h0, {31'h0, err_v});
    xfer(1'b1, 12'h010, 32'h0);
    xfer(1'b0, 12'h010, 32'h0);
    cmp("pslverr unmapped", 32'h1, {31'h0, err_v});
    xfer(1'b1, WCS_CODE_OFS, {24'h0, WCS_CLEAR_CODE});
    xfer(1'b0, WCS_CNT_OFS, 32'h0);
    c = rd_v;
    cmp("count after clear", 32'h1, {31'h0, c < 8});
    xfer(1'b0, WCS_CNT_OFS, 32'h0);
    cmp("count step", c + 3, rd_v);
    nmi_wait();
    st(32'h5D);
    st(32'h59);
    xfer(1'b1, WCS_CTRL_OFS, 32'hA0);
    xfer(1'b0, WCS_CNT_OFS, 32'h0);
    c = rd_v;
    xfer(1'b1, WCS_CODE_OFS, {24'h0, WCS_CLEAR_CODE});
    nmi_wait();
    xfer(1'b0, WCS_CNT_OFS, 32'h0);
    cmp("count kept", 32'h1, {31'h0, rd_v > c});
    st(32'h5B);
    xfer(1'b1, WCS_CODE_OFS, {24'h0, WCS_DISABLE_CODE});
    st(32'h59);
    xfer(1'b1, WCS_CTRL_OFS, 32'h00);
    xfer(1'b1, WCS_CODE_OFS, {24'h0, WCS_DISABLE_CODE});
    st(32'h58);
    xfer(1'b0, WCS_CNT_OFS, 32'h0);
    cmp("stopped count", 32'h0, rd_v);
    xfer(1'b1, WCS_CODE_OFS, 32'h12);
    st(32'h58);
    xfer(1'b1, WCS_CTRL_OFS, 32'h81);
    st(32'h59);
    i = n_nmi;
    repeat (300) if (wdt_reset_req !== 1'b1) @(posedge clk_sys);
    cmp("reset request", 32'h1, {31'h0, wdt_reset_req});
    cmp("no nmi with reset action", i, n_nmi);
    stop_test();
  end
endmodule
`default_nettype wire
